//--- flash_partner.sv
// Behavioural flash device answering reads with a data strobe
`timescale 1ns/1ps
module flash_partner(
	input wire         cs_n,
	input wire         re_n,
	input wire         dq_oe,
	output logic       dqs = 1'b0,
	output logic [7:0] dq = 8'h00
);
	// One new byte per strobe edge, 160 ns strobe period, kept off the clock edges
	always @(negedge re_n)
		if (!cs_n && !dq_oe) begin
			#5;
			while (!cs_n) begin
				#40 if (!cs_n) dq = dq + 8'h01;
				#40 if (!cs_n) dqs = ~dqs;
			end
		end
	// Released bus shows inverted data
	always @(posedge cs_n) dq = ~dq;
endmodule

//--- raw_flash_consts.vh
// Constants for the raw flash port timing sequencer
`ifndef RAW_FLASH_CONSTS_VH
`define RAW_FLASH_CONSTS_VH
// Mode encodings
`define MODE_ASYNC      2'h0
`define MODE_SRC_SYNC   2'h1
`define MODE_TOGGLE     2'h2
`define MODE_NVDDR2     2'h3
// Operation encodings
`define OP_CMD          2'h0
`define OP_ADDR         2'h1
`define OP_WRITE        2'h2
`define OP_READ         2'h3
// Count field width and reset value of counts
`define CNT_W           8
`define CNT_RESET       8'h01
// Strobe delay target field and its typical setting
`define DLY_W           4
`define DLY_TYPICAL     4'h7
// Clock period in ns of the sequencer clock, mclk
`define CLK_PERIOD_NS   20
`endif

//--- raw_flash_port.v
// Raw flash port cycle timing sequencer: sync, toggle and NV-DDR2 modes
//
// Contract
// (RL1) Sync mode chip-select lead, preamble, postamble come from counts times clock.
// (RL2) Toggle strobe and latch timing come from setup, data setup, hold counts.
// (RL3) Address setup may be 0; data setup and hold are at least 1.
// (RL4) DDR read captures 8-bit data on both edges of delayed strobe.
// (RL5) Strobe delay target programmable; 0x7 is about a quarter clock. Here each step is one mclk cycle, so 0x7 delays eight clocks.
// (RL6) Software raises the delay target when board trace delay is large.
// (RL7) NV-DDR2 command and address cycles use asynchronous strobe sequencing.
// (RL8) NV-DDR2 data transfers use toggle-mode double-rate sequencing.
// (RL9) Toggle command and address latches use asynchronous setup and hold counts.
// (RL10) Toggle data phase starts only after latch enables held low long enough.
// (RL11) Sync write first strobe edge comes one clock after flash clock edge.
// (RL12) Software keeps preamble plus one at least setup plus data setup.
`timescale 1ns/1ps
`include "raw_flash_consts.vh"
module raw_flash_port #(
	parameter BURST_W = 8
) (
	input  wire                  mclk,
	input  wire                  reset,
	input  wire [1:0]            mode,
	input  wire [1:0]            op,
	input  wire [7:0]            op_data,
	input  wire [BURST_W-1:0]    burst_len,
	input  wire                  start,
	input  wire [`CNT_W-1:0]     address_setup_cycles,
	input  wire [`CNT_W-1:0]     data_setup_cycles,
	input  wire [`CNT_W-1:0]     data_hold_cycles,
	input  wire [`CNT_W-1:0]     ce_lead_cycles,
	input  wire [`CNT_W-1:0]     preamble_cycles,
	input  wire [`CNT_W-1:0]     postamble_cycles,
	input  wire [`DLY_W-1:0]     read_strobe_delay_target,
	output reg                   busy,
	output reg                   done,
	output reg                   rd_valid,
	output reg  [7:0]            rd_data,
	output reg                   flash_chip_select_n,
	output reg                   flash_cle,
	output reg                   flash_ale,
	output reg                   flash_we_n,
	output reg                   flash_re_n,
	output reg                   flash_clk,
	input  wire                  flash_dqs_in,
	output reg                   flash_dqs_out,
	output reg                   flash_dqs_oe,
	input  wire [7:0]            flash_dq_in,
	output reg  [7:0]            flash_dq_out,
	output reg                   flash_dq_oe
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_LEAD = 7'h02;
localparam [6:0] ST_SETUP = 7'h04;
localparam [6:0] ST_PULSE = 7'h08;
localparam [6:0] ST_HOLD = 7'h10;
localparam [6:0] ST_DATA = 7'h20;
localparam [6:0] ST_POST = 7'h40;

reg [6:0]         state;
reg [`CNT_W-1:0]  cnt;
reg [BURST_W:0]   beats;
reg               is_data;
reg [1:0]         op_q;
reg [1:0]         mode_q;
reg [7:0]         wdata;

// ----------------------------------------
// Input synchronisers and delayed strobe
// ----------------------------------------
reg  [1:0] dqs_sync;
reg  [7:0] dq_s1;
reg  [7:0] dq_s2;
reg  [15:0] dqs_line;
reg  [7:0]  dq_line [0:15];
wire [3:0]  tap = read_strobe_delay_target;
wire        dqs_del = dqs_line[tap];
reg         dqs_del_q;
integer     k;

always @(posedge mclk or posedge reset) begin
	if (reset) begin
		dqs_sync <= 2'h0;
		dq_s1 <= 8'h00;
		dq_s2 <= 8'h00;
		dqs_line <= 16'h0000;
		dqs_del_q <= 1'b0;
	end else begin
		dqs_sync <= {dqs_sync[0], flash_dqs_in};
		dq_s1 <= flash_dq_in;
		dq_s2 <= dq_s1;
		// Programmable delay line on the strobe [RL5]
		dqs_line <= {dqs_line[14:0], dqs_sync[1]};
		dqs_del_q <= dqs_del;
	end
end

always @(posedge mclk) begin
	dq_line[0] <= dq_s2;
	for (k = 1; k < 16; k = k + 1)
		dq_line[k] <= dq_line[k-1];
end

// Both edges of the delayed strobe capture data [RL4]
wire dqs_edge = dqs_del ^ dqs_del_q;

// ----------------------------------------
// Timing counts, clamped to legal minimums
// ----------------------------------------
wire [`CNT_W-1:0] ds_c = (data_setup_cycles == 8'h00) ? 8'h01 : data_setup_cycles; // [RL3]
wire [`CNT_W-1:0] dh_c = (data_hold_cycles == 8'h00) ? 8'h01 : data_hold_cycles; // [RL3]
wire              sync_mode = (mode_q == `MODE_SRC_SYNC);
wire              ddr_data = (mode_q == `MODE_TOGGLE) || (mode_q == `MODE_NVDDR2); // [RL8]

// ----------------------------------------
// Sequencer
// ----------------------------------------
always @(posedge mclk or posedge reset) begin
	if (reset) begin
		state <= ST_IDLE;
		cnt <= 8'h00;
		beats <= {(BURST_W+1){1'b0}};
		is_data <= 1'b0;
		op_q <= 2'h0;
		mode_q <= 2'h0;
		wdata <= 8'h00;
		busy <= 1'b0;
		done <= 1'b0;
		rd_valid <= 1'b0;
		rd_data <= 8'h00;
		flash_chip_select_n <= 1'b1;
		flash_cle <= 1'b0;
		flash_ale <= 1'b0;
		flash_we_n <= 1'b1;
		flash_re_n <= 1'b1;
		flash_clk <= 1'b0;
		flash_dqs_out <= 1'b0;
		flash_dqs_oe <= 1'b0;
		flash_dq_out <= 8'h00;
		flash_dq_oe <= 1'b0;
	end else begin
		done <= 1'b0;
		rd_valid <= 1'b0;
		if (sync_mode && busy)
			flash_clk <= ~flash_clk;
		case (state)
		ST_IDLE: begin
			flash_clk <= 1'b0;
			if (start) begin
				busy <= 1'b1;
				mode_q <= mode;
				op_q <= op;
				wdata <= op_data;
				is_data <= op[1];
				beats <= {1'b0, burst_len};
				flash_chip_select_n <= 1'b0;
				// Chip-select lead time before anything else [RL1]
				cnt <= (mode == `MODE_SRC_SYNC) ? ce_lead_cycles : 8'h00;
				state <= ST_LEAD;
			end
		end
		ST_LEAD: begin
			if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end else if (is_data && (ddr_data || sync_mode)) begin
				// Latch enables already low; preamble gives them time [RL10]
				flash_cle <= 1'b0;
				flash_ale <= 1'b0;
				flash_re_n <= (op_q == `OP_READ) ? 1'b0 : 1'b1;
				flash_dqs_oe <= (op_q == `OP_WRITE);
				flash_dqs_out <= 1'b0;
				cnt <= preamble_cycles; // [RL1] [RL2]
				state <= ST_SETUP;
			end else begin
				// Asynchronous style latch cycle for command, address [RL7] [RL9]
				flash_cle <= (op_q == `OP_CMD);
				flash_ale <= (op_q == `OP_ADDR);
				flash_dq_out <= wdata;
				flash_dq_oe <= (op_q != `OP_READ);
				cnt <= address_setup_cycles; // [RL2]
				state <= ST_SETUP;
			end
		end
		ST_SETUP: begin
			if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end else if (is_data && (ddr_data || sync_mode)) begin
				flash_dq_oe <= (op_q == `OP_WRITE);
				flash_dq_out <= wdata;
				// First strobe edge one clock later [RL11]
				state <= ST_DATA;
			end else begin
				flash_we_n <= (op_q == `OP_READ);
				flash_re_n <= (op_q != `OP_READ);
				cnt <= ds_c - 8'h01; // [RL2] [RL3]
				state <= ST_PULSE;
			end
		end
		ST_PULSE: begin
			if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end else begin
				if (op_q == `OP_READ) begin
					rd_data <= dq_s2;
					rd_valid <= 1'b1;
				end
				flash_we_n <= 1'b1;
				flash_re_n <= 1'b1;
				cnt <= dh_c - 8'h01; // [RL2] [RL3]
				state <= ST_HOLD;
			end
		end
		ST_HOLD: begin
			if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end else begin
				flash_cle <= 1'b0;
				flash_ale <= 1'b0;
				flash_dq_oe <= 1'b0;
				cnt <= 8'h00;
				state <= ST_POST;
			end
		end
		ST_DATA: begin
			if (op_q == `OP_WRITE) begin
				flash_dqs_out <= ~flash_dqs_out;
				beats <= beats - {{BURST_W{1'b0}}, 1'b1};
				if (beats == {(BURST_W+1){1'b0}}) begin
					flash_dqs_out <= 1'b0;
					cnt <= postamble_cycles; // [RL1]
					state <= ST_POST;
				end
			end else begin
				flash_re_n <= ~flash_re_n;
				if (dqs_edge) begin
					rd_data <= dq_line[tap]; // [RL4]
					rd_valid <= 1'b1;
					beats <= beats - {{BURST_W{1'b0}}, 1'b1};
					if (beats == {(BURST_W+1){1'b0}}) begin
						cnt <= postamble_cycles; // [RL1]
						state <= ST_POST;
					end
				end
			end
		end
		ST_POST: begin
			if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end else begin
				flash_re_n <= 1'b1;
				flash_dqs_oe <= 1'b0;
				flash_dq_oe <= 1'b0;
				flash_chip_select_n <= 1'b1;
				busy <= 1'b0;
				done <= 1'b1;
				state <= ST_IDLE;
			end
		end
		default: state <= ST_IDLE;
		endcase
	end
end

endmodule

//--- raw_flash_port_sva.sv
// Checker on the top ports of the raw flash port sequencer
`timescale 1ns/1ps
module raw_flash_port_sva(
	input wire       mclk,
	input wire       reset,
	input wire       start,
	input wire       busy,
	input wire       done,
	input wire [1:0] mode,
	input wire [7:0] data_setup_cycles,
	input wire [7:0] data_hold_cycles,
	input wire       flash_chip_select_n,
	input wire       flash_cle,
	input wire       flash_ale,
	input wire       flash_we_n,
	input wire       flash_re_n,
	input wire       flash_clk,
	input wire       flash_dqs_oe,
	input wire       flash_dq_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	property p_start_taken; start && !busy |=> busy; endproperty
	a_start_taken: assert property (p_start_taken) else $error("start not taken");
	property p_cs_lead; $rose(busy) |-> !flash_chip_select_n; endproperty
	a_cs_lead: assert property (p_cs_lead) else $error("select late");
	property p_done_end; done |-> !busy && flash_chip_select_n ##1 !done; endproperty
	a_done_end: assert property (p_done_end) else $error("bad done");
	property p_we_width;
		$fell(flash_we_n) && flash_cle && data_setup_cycles == 8'h02 |=> !flash_we_n ##1 flash_we_n;
	endproperty
	a_we_width: assert property (p_we_width) else $error("strobe width");
	property p_ds_min; $fell(flash_we_n) && data_setup_cycles == 8'h00 |=> flash_we_n; endproperty
	a_ds_min: assert property (p_ds_min) else $error("zero setup count");
	property p_hold; $rose(flash_we_n) && flash_cle && data_hold_cycles == 8'h01 |=> !flash_cle;
	endproperty
	a_hold: assert property (p_hold) else $error("latch hold");
	property p_sync_clk; busy && $past(busy) && mode == 2'h1 |-> flash_clk != $past(flash_clk);
	endproperty
	a_sync_clk: assert property (p_sync_clk) else $error("flash clock stalled");
	property p_latch_low; flash_dqs_oe |-> !flash_cle && !flash_ale; endproperty
	a_latch_low: assert property (p_latch_low) else $error("latch during data");
	property p_idle_quiet; !busy |-> !flash_dq_oe && !flash_dqs_oe; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("drives when idle");
	property p_re_idle; !busy |-> flash_re_n; endproperty
	a_re_idle: assert property (p_re_idle) else $error("read strobe when idle");
endmodule
bind raw_flash_port raw_flash_port_sva chk_i(
	.mclk                (mclk),
	.reset               (reset),
	.start               (start),
	.busy                (busy),
	.done                (done),
	.mode                (mode),
	.data_setup_cycles   (data_setup_cycles),
	.data_hold_cycles    (data_hold_cycles),
	.flash_chip_select_n (flash_chip_select_n),
	.flash_cle           (flash_cle),
	.flash_ale           (flash_ale),
	.flash_we_n          (flash_we_n),
	.flash_re_n          (flash_re_n),
	.flash_clk           (flash_clk),
	.flash_dqs_oe        (flash_dqs_oe),
	.flash_dq_oe         (flash_dq_oe)
);

//--- raw_flash_port_test.sv
// Testbench for the raw flash port sequencer
`timescale 1ns/1ps
module raw_flash_port_test;
	logic mclk = 0, reset = 1, start = 0;
	logic [1:0] mode = 0, op = 0;
	logic [7:0] op_data = 0, burst_len = 0, as_c = 0, ds_c = 1, dh_c = 1, lead = 1, pre = 1, post = 1;
	logic [3:0] dly = 4'h7;
	logic [7:0] last_rd, we_byte;
	logic we_q, dqs_q;
	int re_lo, dqs_ed;
	wire busy, done, rd_valid, cs_n, cle, ale, we_n, re_n, fclk, dqs, dqs_o, dqs_oe, dq_oe;
	wire [7:0] rd_data, dq, dq_o;
	int err_total = 0, check_count = 0, cyc = 0, we_lo, cs_lo, rdv, clk_ed, rd_bad, wbad;
	always #10 mclk = ~mclk;
	raw_flash_port dut(.mclk, .reset, .mode, .op, .op_data, .burst_len, .start,
		.address_setup_cycles(as_c), .data_setup_cycles(ds_c), .data_hold_cycles(dh_c),
		.ce_lead_cycles(lead), .preamble_cycles(pre), .postamble_cycles(post),
		.read_strobe_delay_target(dly), .busy, .done, .rd_valid, .rd_data,
		.flash_chip_select_n(cs_n), .flash_cle(cle), .flash_ale(ale), .flash_we_n(we_n),
		.flash_re_n(re_n), .flash_clk(fclk), .flash_dqs_in(dqs), .flash_dqs_out(dqs_o),
		.flash_dqs_oe(dqs_oe), .flash_dq_in(dq), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe));
	flash_partner fp(.cs_n, .re_n, .dq_oe, .dqs, .dq);
	always @(posedge mclk) begin
		cyc++;
		we_lo += !we_n;
		re_lo += !re_n;
		cs_lo += !cs_n;
		clk_ed += fclk;
		dqs_ed += (dqs_o !== dqs_q);
		dqs_q = dqs_o;
		if (we_n && !we_q && (cle || ale)) we_byte = dq_o;
		we_q = we_n;
		if (dqs_oe && dq_oe && dq_o !== op_data) wbad++;
		if (rd_valid) begin
			if (rdv > 0 && rd_data !== last_rd + 8'h01) rd_bad++;
			last_rd = rd_data;
			rdv++;
		end
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	task chk(input bit ok, input string m);
		check_count++;
		if (!ok) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task run(input [1:0] m, input [1:0] o, input [7:0] d, input [7:0] bl);
		int n;
		@(posedge mclk);
		#1 {we_lo, re_lo, cs_lo, rdv, clk_ed, dqs_ed, rd_bad, wbad} = 0;
		@(posedge mclk);
		{mode, op, op_data, burst_len, start} <= {m, o, d, bl, 1'b1};
		@(posedge mclk) start <= 0;
		n = 0;
		while (done !== 1'b1 && n < 600) begin
			@(posedge mclk);
			n++;
		end
		chk(n < 600, "no done");
	endtask
	task t_cmd;
		{as_c, ds_c, dh_c} <= {8'h00, 8'h02, 8'h01};
		run(2'h2, 2'h0, 8'h3C, 8'h00);
		chk(we_lo == 2, "strobe width");
		chk(we_byte === 8'h3C, "command byte");
	endtask
	task t_addr;
		ds_c <= 8'h00;
		run(2'h3, 2'h1, 8'h5A, 8'h00);
		chk(we_lo == 1, "zero setup count");
		chk(we_byte === 8'h5A, "address byte");
	endtask
	task t_write;
		{lead, pre, post, ds_c} <= {8'h02, 8'h03, 8'h02, 8'h01};
		run(2'h1, 2'h2, 8'hC3, 8'h03);
		chk(cs_lo == 14, "lead, preamble, postamble");
		chk(clk_ed == 7 && wbad == 0, "write burst");
		chk(dqs_ed == 4, "write strobe edges");
	endtask
	task t_async_read;
		run(2'h0, 2'h3, 8'h00, 8'h00);
		chk(re_lo == 1 && rdv == 1, "read strobe width");
	endtask
	task t_read(input [1:0] m, input [3:0] d);
		dly <= d;
		run(m, 2'h3, 8'h00, 8'h03);
		repeat (20) @(posedge mclk);
		chk(rdv == 4, "beat count");
		chk(rd_bad == 0, "byte order");
	endtask
	task finish_test;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		reset <= 0;
		t_cmd;
		t_addr;
		t_write;
		t_read(2'h2, 4'h7);
		t_read(2'h3, 4'h9);
		t_read(2'h1, 4'h7);
		t_async_read;
		finish_test;
	end
endmodule
